/* File: common/tlpu_pkg.sv */
// Summary of operation
// - fault address register keeps the full 32-bit linear address of the last fault
// - directory base register low 12 bits always read and hold zero
// - directory base write or base-changing task switch flushes every cache entry
// - linear bits 31..22 index the 1024-entry page directory at the base
// - linear bits 21..12 index the 1024-entry page table from the directory
// - physical address is 20-bit frame joined with low 12 linear bits
// - entry bit 0 is present; only present entries translate
// - accessed bit 5 set in directory and table entries before the access
// - dirty bit 6 of table entry set before any write; directory bit 6 unused
// - flag updates are done as bus-locked read-modify-write cycles
// - entry bits 9..11 are never interpreted nor modified by hardware
// - user level: user clear none, user set write clear read-only, both read-write
// - privilege levels 0, 1, 2 are supervisor and bypass page protection
// - effective protection is the numerically smaller of directory and table pairs
// - cache holds 32 table entries, four-way set associative, one 4K page each
// - bits 14..12 pick the set, upper 17 bits compared; read or dirty hit gives physical address with no table access
// - miss reads directory and sets its accessed bit, then reads and updates the table entry, then caches translation
// - not-present directory or table entry raises page fault 14
// - protection violation raises fault 14 and loads the fault address register
// - fault while entering a fault handler raises 14 again, never vector 8
// - page fault is a fault, pointer stays at instruction, 16-bit code given
// - code reports user mode, write direction and protection cause
// - descriptor table access faults report supervisor mode even at level 3
package tlpu_pkg;
    localparam int          TLPU_ENTRIES  = 32;
    localparam int          TLPU_WAYS     = 4;
    localparam int          TLPU_SETS     = TLPU_ENTRIES / TLPU_WAYS;
    localparam int          TLPU_SET_W    = 3;
    localparam int          TLPU_TAG_W    = 20 - TLPU_SET_W;
    localparam int          TLPU_OFS_W    = 12;
    localparam int          TLPU_BIT_P    = 0;
    localparam int          TLPU_BIT_RW   = 1;
    localparam int          TLPU_BIT_US   = 2;
    localparam int          TLPU_BIT_A    = 5;
    localparam int          TLPU_BIT_D    = 6;
    localparam int          TLPU_ERR_P    = 0;
    localparam int          TLPU_ERR_WR   = 1;
    localparam int          TLPU_ERR_US   = 2;
    localparam logic [7:0]  TLPU_VEC_PF   = 8'h0E;
    localparam logic [31:0] TLPU_FLA_RST  = 32'h0000_0000;
    localparam logic [31:0] TLPU_DBA_RST  = 32'h0000_0000;
    localparam logic [1:0]  TLPU_CPL_USER = 2'h3;
endpackage

/* File: dv/tb.sv */
`timescale 1ns/1ps
// ------------------------------------
// paging unit bench
// ------------------------------------
module tb;
    import tlpu_pkg::*;
    typedef struct {
        logic        f;
        logic [31:0] v;
        logic [15:0] e;
    } tlpu_exp_type;
    localparam logic [31:0] DBA = 32'h0010_0000;
    logic        mclk_i, rst_b_i, dba_wr_i, task_sw_i, task_ctl_chg_i;
    logic        fla_wr_i, req_i, write_i, desc_acc_i, in_pf_entry_i;
    logic        mem_ack_i, mem_req_o, mem_we_o, mem_lock_o;
    logic        done_o, fault_o, busy_o, usr, bad;
    logic [31:0] dba_wdata_i, fla_wdata_i, lin_i, mem_rdata_i, l, pv;
    logic [31:0] mem_addr_o, mem_wdata_o, phys_o, fla_o, dba_o;
    logic [19:0] fr;
    logic [15:0] err_code_o;
    logic [7:0]  fault_vec_o;
    logic [1:0]  cpl_i, dly, mn, c;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          seed = 74;
    int          acks, unlocked, a;
    tlpu_exp_type exp_q[$];
    tlpu_exp_type m;
    tlpu_top tlpu_top_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .dba_wr_i(dba_wr_i), .dba_wdata_i(dba_wdata_i),
        .task_sw_i(task_sw_i), .task_ctl_chg_i(task_ctl_chg_i),
        .fla_wr_i(fla_wr_i), .fla_wdata_i(fla_wdata_i), .req_i(req_i),
        .lin_i(lin_i), .write_i(write_i), .cpl_i(cpl_i),
        .desc_acc_i(desc_acc_i), .in_pf_entry_i(in_pf_entry_i),
        .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
        .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
        .mem_lock_o(mem_lock_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .done_o(done_o), .phys_o(phys_o),
        .fault_o(fault_o), .fault_vec_o(fault_vec_o),
        .err_code_o(err_code_o), .busy_o(busy_o), .fla_o(fla_o),
        .dba_o(dba_o));
    tlpu_mem tlpu_mem_inst (.mclk_i(mclk_i), .req_i(mem_req_o),
        .we_i(mem_we_o), .lock_i(mem_lock_o), .addr_i(mem_addr_o),
        .wdata_i(mem_wdata_o), .dly_i(dly), .ack_o(mem_ack_i),
        .rdata_o(mem_rdata_i), .acks_o(acks), .unlocked_o(unlocked));
    task automatic check(string n, logic [31:0] s, logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, x, s);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [19:0] tf(logic [31:0] x);
        return {10'h200, x[31:22]};
    endfunction
    function automatic logic [31:0] pde_a(logic [31:0] x);
        return {DBA[31:12], x[31:22], 2'b00};
    endfunction
    function automatic logic [31:0] pte_a(logic [31:0] x);
        return {tf(x), x[21:12], 2'b00};
    endfunction
    function automatic logic [31:0] rd(logic [31:0] x);
        return tlpu_mem_inst.mem[x];
    endfunction
    // software field is seeded so any hardware touch of it shows
    task automatic map(logic [31:0] x, logic [1:0] pa, logic [1:0] ta,
                       logic pp, logic tp, logic [19:0] f);
        tlpu_mem_inst.mem[pde_a(x)] = {tf(x), 3'h5, 6'h0, pa, pp};
        tlpu_mem_inst.mem[pte_a(x)] = {f, 3'h2, 6'h0, ta, tp};
    endtask
    task automatic acc(logic [31:0] x, logic w, logic [1:0] p, logic d,
                       logic f, logic [31:0] v, logic [15:0] e);
        int n;
        exp_q.push_back('{f, v, e});
        dly = 2'($random(seed));
        req_i = 1'b1;
        lin_i = x;
        write_i = w;
        cpl_i = p;
        desc_acc_i = d;
        in_pf_entry_i = 1'($random(seed));
        @(negedge mclk_i);
        req_i = 1'b0;
        n = 0;
        while ((exp_q.size() != 0 || busy_o !== 1'b0) && n < 99) begin
            @(negedge mclk_i);
            n++;
        end
        @(negedge mclk_i);
    endtask
    task automatic set_dba(logic [31:0] v);
        dba_wdata_i = v;
        dba_wr_i = 1'b1;
        @(negedge mclk_i);
        dba_wr_i = 1'b0;
        check("dba", dba_o, v & 32'hFFFF_F000);
    endtask
    task automatic tsw(logic chg);
        task_sw_i = 1'b1;
        task_ctl_chg_i = chg;
        @(negedge mclk_i);
        task_sw_i = 1'b0;
        task_ctl_chg_i = 1'b0;
    endtask
    // ------------------------------------
    // answer watcher
    // ------------------------------------
    always @(negedge mclk_i) begin
        if (done_o === 1'b1 || fault_o === 1'b1) begin
            m = exp_q.pop_front();
            check("fault", fault_o, m.f);
            if (m.f) begin
                check("vec", fault_vec_o, 8'h0E);
                check("err", err_code_o, m.e);
                @(negedge mclk_i);
                check("fla", fla_o, m.v);
            end else begin
                check("phys", phys_o, m.v);
            end
        end
    end
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (30000) @(negedge mclk_i);
        error_cnt++;
        stop_test();
    end
    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial begin
        {rst_b_i, dba_wr_i, task_sw_i, task_ctl_chg_i, fla_wr_i} = '0;
        {req_i, write_i, desc_acc_i, in_pf_entry_i, cpl_i, dly} = '0;
        {dba_wdata_i, fla_wdata_i, lin_i} = '0;
        repeat (8) @(negedge mclk_i);
        rst_b_i = 1'b1;
        set_dba(DBA | 32'h0000_0ABC);
        l = 32'hFC03_5123;
        map(l, 2'h3, 2'h3, 1'b1, 1'b1, 20'h11111);
        acc(l, 1'b0, 2'h0, 1'b0, 1'b0, {20'h11111, 12'h123}, 16'h0);
        a = acks;
        acc({l[31:12], 12'h456}, 0, 0, 0, 0, {20'h11111, 12'h456}, 0);
        check("acks", acks, a);
        acc(l, 1'b1, 2'h0, 1'b0, 1'b0, {20'h11111, 12'h123}, 16'h0);
        check("dirty", rd(pte_a(l)), {20'h11111, 12'h467});
        map(l, 2'h3, 2'h3, 1'b1, 1'b1, 20'h22222);
        tsw(1'b0);
        acc(l, 1'b0, 2'h0, 1'b0, 1'b0, {20'h11111, 12'h123}, 16'h0);
        tsw(1'b1);
        acc(l, 1'b0, 2'h0, 1'b0, 1'b0, {20'h22222, 12'h123}, 16'h0);
        map(l, 2'h3, 2'h3, 1'b1, 1'b1, 20'h33333);
        set_dba(DBA);
        acc(l, 1'b0, 2'h0, 1'b0, 1'b0, {20'h33333, 12'h123}, 16'h0);
        $display("test flush done");
        for (int i = 0; i < 64; i++) begin
            l = {i[9:0] + 10'h10, i[9:0], 12'($random(seed))};
            fr = {10'h155, i[9:0]};
            map(l, i[1:0], i[3:2], 1'b1, 1'b1, fr);
            mn = (i[1:0] < i[3:2]) ? i[1:0] : i[3:2];
            usr = i[5];
            bad = usr && (!mn[1] || (i[4] && !mn[0]));
            pv = bad ? l : {fr, l[11:0]};
            c = usr ? 2'h3 : 2'($unsigned($random(seed)) % 3);
            acc(l, i[4], c, 1'b0, bad, pv, {13'h0, usr, i[4], 1'b1});
            check("pde", rd(pde_a(l)),
                  {tf(l), 3'h5, 6'h0, i[1:0], 1'b1} | 32'h20);
            if (!bad) check("pte", rd(pte_a(l)),
                  {fr, 3'h2, 6'h0, i[3:2], 1'b1} | {25'h0, i[4], 1'b1, 5'h0});
        end
        $display("test protection done");
        for (int k = 0; k < 8; k++) begin
            l = {10'h300 + 10'(k), 10'h0AA, 12'h010};
            map(l, 2'h3, 2'h3, k[0], 1'b0, 20'h0);
            acc(l, k[1], 2'h3, k[2], 1'b1, l,
                {13'h0, !k[2], k[1], 1'b0});
        end
        $display("test not present done");
        fla_wdata_i = $random(seed);
        fla_wr_i = 1'b1;
        @(negedge mclk_i);
        fla_wr_i = 1'b0;
        check("fla_sw", fla_o, fla_wdata_i);
        check("unlocked", unlocked, 0);
        $display("test registers done");
        stop_test();
    end
endmodule

/* File: dv/tlpu_mem.sv */
`timescale 1ns/1ps
// ------------------------------------
// memory on the walk bus
// ------------------------------------
module tlpu_mem (
    // design side
    input  wire logic        mclk_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic        lock_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    // bench delay in, answer back to the design, counters to the bench
    input  wire logic [1:0]  dly_i,
    output logic             ack_o,
    output logic [31:0]      rdata_o,
    output int               acks_o,
    output int               unlocked_o
);
    logic [31:0] mem [logic [31:0]];
    int          cnt = 0;
    initial begin
        ack_o = 1'b0;
        rdata_o = 32'h0;
        acks_o = 0;
        unlocked_o = 0;
    end
    // read data flips outside read acks so stale words never look valid
    always @(posedge mclk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            if (cnt < dly_i) begin
                cnt <= cnt + 1;
            end else begin
                cnt <= 0;
                ack_o <= 1'b1;
                acks_o <= acks_o + 1;
                if (!lock_i) begin
                    unlocked_o <= unlocked_o + 1;
                end
                if (we_i) begin
                    mem[addr_i] = wdata_i;
                end else begin
                    rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 32'h0;
                end
            end
        end
    end
endmodule

/* File: hw/tlpu_lru.sv */
`timescale 1ns/1ps
// pseudo-lru replacement per set; tree of three bits
module tlpu_lru #(
    parameter int SETS = 8
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       flush_i,
    input  wire logic       touch_i,
    input  wire logic [2:0] tset_i,
    input  wire logic [1:0] tway_i,
    input  wire logic [2:0] qset_i,
    output logic      [1:0] victim_o
);
    logic [2:0] tree_q [SETS];

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || flush_i) begin
            for (int i = 0; i < SETS; i++) begin
                tree_q[i] <= 3'h0;
            end
        end else if (touch_i) begin
            tree_q[tset_i][0] <= ~tway_i[1];
            if (tway_i[1]) begin
                tree_q[tset_i][2] <= ~tway_i[0];
            end else begin
                tree_q[tset_i][1] <= ~tway_i[0];
            end
        end
    end

    always_comb begin
        victim_o[1] = tree_q[qset_i][0];
        victim_o[0] = tree_q[qset_i][0] ? tree_q[qset_i][2]
                                        : tree_q[qset_i][1];
    end
endmodule

/* File: hw/tlpu_top.sv */
`timescale 1ns/1ps
module tlpu_top
    import tlpu_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // control register writes
    input  wire logic        dba_wr_i,
    input  wire logic [31:0] dba_wdata_i,
    input  wire logic        task_sw_i,
    input  wire logic        task_ctl_chg_i,
    input  wire logic        fla_wr_i,
    input  wire logic [31:0] fla_wdata_i,
    // request from segmentation unit
    input  wire logic        req_i,
    input  wire logic [31:0] lin_i,
    input  wire logic        write_i,
    input  wire logic [1:0]  cpl_i,
    input  wire logic        desc_acc_i,
    input  wire logic        in_pf_entry_i,
    // memory bus
    input  wire logic        mem_ack_i,
    input  wire logic [31:0] mem_rdata_i,
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic             mem_lock_o,
    output logic [31:0]      mem_addr_o,
    output logic [31:0]      mem_wdata_o,
    // answer
    output logic             done_o,
    output logic [31:0]      phys_o,
    output logic             fault_o,
    output logic [7:0]       fault_vec_o,
    output logic [15:0]      err_code_o,
    output logic             busy_o,
    // register read-back
    output logic [31:0]      fla_o,
    output logic [31:0]      dba_o
);
    import tlpu_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_LOOK = 3'b001,
        S_PDE  = 3'b010,
        S_PDEW = 3'b011,
        S_PTE  = 3'b100,
        S_PTEW = 3'b101,
        S_FILL = 3'b110
    } tlpu_state_type;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [1:0] rights(input logic [31:0] e);
        return {e[TLPU_BIT_US], e[TLPU_BIT_RW]};
    endfunction

    // user access check on combined rights, supervisor always passes
    function automatic logic allowed(input logic [1:0] r, input logic wr,
                                     input logic [1:0] cpl);
        if (cpl != TLPU_CPL_USER) begin
            return 1'b1;
        end
        return r[1] && (r[0] || !wr);
    endfunction

    function automatic logic [1:0] min2(input logic [1:0] a,
                                        input logic [1:0] b);
        return (a < b) ? a : b;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    tlpu_state_type st_q;
    logic [31:0]    lin_q;
    logic           wr_q;
    logic [1:0]     cpl_q;
    logic           desc_q;
    logic [31:0]    pde_q;
    logic [31:0]    pte_q;
    logic           flush;

    logic                  v_q   [TLPU_SETS][TLPU_WAYS];
    logic [TLPU_TAG_W-1:0] tag_q [TLPU_SETS][TLPU_WAYS];
    logic [19:0]           frm_q [TLPU_SETS][TLPU_WAYS];
    logic [1:0]            rt_q  [TLPU_SETS][TLPU_WAYS];
    logic                  dty_q [TLPU_SETS][TLPU_WAYS];

    logic [TLPU_SET_W-1:0] set_idx;
    logic [TLPU_TAG_W-1:0] tag_val;
    logic                  hit;
    logic [1:0]            hway;
    logic [1:0]            victim;
    logic                  touch;
    logic [1:0]            touch_way;

    assign set_idx = lin_q[TLPU_OFS_W +: TLPU_SET_W];
    assign tag_val = lin_q[31 -: TLPU_TAG_W];
    assign flush   = dba_wr_i || (task_sw_i && task_ctl_chg_i);

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            dba_o <= TLPU_DBA_RST;
        end else if (dba_wr_i) begin
            dba_o <= {dba_wdata_i[31:12], 12'h000};
        end
    end

    logic pf_set;
    assign pf_set = fault_o;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            fla_o <= TLPU_FLA_RST;
        end else if (pf_set) begin
            fla_o <= lin_q;
        end else if (fla_wr_i) begin
            fla_o <= fla_wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // translation cache lookup
    // ------------------------------------------------------------------
    always_comb begin
        hit  = 1'b0;
        hway = 2'h0;
        for (int w = 0; w < TLPU_WAYS; w++) begin
            if (v_q[set_idx][w] && tag_q[set_idx][w] == tag_val) begin
                hit  = 1'b1;
                hway = 2'(w);
            end
        end
    end

    tlpu_lru #(
        .SETS    (TLPU_SETS)
    ) u_lru (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .flush_i (flush),
        .touch_i (touch),
        .tset_i  (set_idx),
        .tway_i  (touch_way),
        .qset_i  (set_idx),
        .victim_o(victim)
    );

    // a cached write needs a clean-to-dirty walk, so only read or
    // already-dirty hits finish from the cache
    logic hit_ok;
    assign hit_ok = hit && (!wr_q || dty_q[set_idx][hway]);
    assign touch  = (st_q == S_LOOK && hit_ok) || st_q == S_FILL;
    assign touch_way = (st_q == S_FILL) ? victim : hway;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || flush) begin
            for (int s = 0; s < TLPU_SETS; s++) begin
                for (int w = 0; w < TLPU_WAYS; w++) begin
                    v_q[s][w] <= 1'b0;
                end
            end
        end else if (st_q == S_FILL) begin
            v_q[set_idx][victim] <= 1'b1;
        end else if (st_q == S_LOOK && hit && !hit_ok) begin
            v_q[set_idx][hway] <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (st_q == S_FILL) begin
            tag_q[set_idx][victim] <= tag_val;
            frm_q[set_idx][victim] <= pte_q[31:12];
            rt_q[set_idx][victim]  <= min2(rights(pde_q), rights(pte_q));
            dty_q[set_idx][victim] <= pte_q[TLPU_BIT_D];
        end
    end

    // ------------------------------------------------------------------
    // walk sequencer
    // ------------------------------------------------------------------
    logic [1:0] eff_rt;
    logic [1:0] mode_cpl;
    assign eff_rt   = min2(rights(pde_q), rights(mem_rdata_i));
    // descriptor table walks count as supervisor for the error code
    assign mode_cpl = desc_q ? 2'h0 : cpl_q;

    function automatic logic [15:0] ecode(input logic prot, input logic wr,
                                          input logic usr);
        logic [15:0] c;
        c = 16'h0000;
        c[TLPU_ERR_P]  = prot;
        c[TLPU_ERR_WR] = wr;
        c[TLPU_ERR_US] = usr;
        return c;
    endfunction

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st_q        <= S_IDLE;
            lin_q       <= 32'h0000_0000;
            wr_q        <= 1'b0;
            cpl_q       <= 2'h0;
            desc_q      <= 1'b0;
            pde_q       <= 32'h0000_0000;
            pte_q       <= 32'h0000_0000;
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_lock_o  <= 1'b0;
            mem_addr_o  <= 32'h0000_0000;
            mem_wdata_o <= 32'h0000_0000;
            done_o      <= 1'b0;
            phys_o      <= 32'h0000_0000;
            fault_o     <= 1'b0;
            fault_vec_o <= 8'h00;
            err_code_o  <= 16'h0000;
            busy_o      <= 1'b0;
        end else begin
            done_o  <= 1'b0;
            fault_o <= 1'b0;
            unique case (st_q)
                S_IDLE: begin
                    if (req_i) begin
                        lin_q  <= lin_i;
                        wr_q   <= write_i;
                        cpl_q  <= cpl_i;
                        desc_q <= desc_acc_i;
                        busy_o <= 1'b1;
                        st_q   <= S_LOOK;
                    end
                end
                S_LOOK: begin
                    if (hit_ok) begin
                        if (allowed(rt_q[set_idx][hway], wr_q, cpl_q)) begin
                            phys_o <= {frm_q[set_idx][hway],
                                       lin_q[11:0]};
                            done_o <= 1'b1;
                        end else begin
                            fault_o     <= 1'b1;
                            fault_vec_o <= TLPU_VEC_PF;
                            err_code_o  <= ecode(1'b1, wr_q,
                                                 mode_cpl == TLPU_CPL_USER);
                        end
                        busy_o <= 1'b0;
                        st_q   <= S_IDLE;
                    end else begin
                        mem_req_o  <= 1'b1;
                        mem_we_o   <= 1'b0;
                        mem_lock_o <= 1'b1;
                        mem_addr_o <= {dba_o[31:12], lin_q[31:22],
                                       2'b00};
                        st_q       <= S_PDE;
                    end
                end
                S_PDE: begin
                    if (mem_ack_i) begin
                        pde_q <= mem_rdata_i;
                        if (!mem_rdata_i[TLPU_BIT_P]) begin
                            mem_req_o   <= 1'b0;
                            mem_lock_o  <= 1'b0;
                            fault_o     <= 1'b1;
                            fault_vec_o <= TLPU_VEC_PF;
                            err_code_o  <= ecode(1'b0, wr_q,
                                                 mode_cpl == TLPU_CPL_USER);
                            busy_o      <= 1'b0;
                            st_q        <= S_IDLE;
                        end else begin
                            // only bit 5 changes; software bits ride along
                            mem_we_o    <= 1'b1;
                            mem_wdata_o <= mem_rdata_i |
                                           (32'h1 << TLPU_BIT_A);
                            st_q        <= S_PDEW;
                        end
                    end
                end
                S_PDEW: begin
                    if (mem_ack_i) begin
                        mem_we_o   <= 1'b0;
                        mem_addr_o <= {pde_q[31:12], lin_q[21:12],
                                       2'b00};
                        st_q       <= S_PTE;
                    end
                end
                S_PTE: begin
                    if (mem_ack_i) begin
                        pte_q <= mem_rdata_i;
                        if (!mem_rdata_i[TLPU_BIT_P] ||
                            !allowed(eff_rt, wr_q, cpl_q)) begin
                            mem_req_o   <= 1'b0;
                            mem_lock_o  <= 1'b0;
                            fault_o     <= 1'b1;
                            fault_vec_o <= TLPU_VEC_PF;
                            err_code_o  <= ecode(mem_rdata_i[TLPU_BIT_P],
                                                 wr_q,
                                                 mode_cpl == TLPU_CPL_USER);
                            busy_o      <= 1'b0;
                            st_q        <= S_IDLE;
                        end else begin
                            mem_we_o    <= 1'b1;
                            mem_wdata_o <= mem_rdata_i |
                                           (32'h1 << TLPU_BIT_A) |
                                           (32'(wr_q) << TLPU_BIT_D);
                            st_q        <= S_PTEW;
                        end
                    end
                end
                S_PTEW: begin
                    if (mem_ack_i) begin
                        mem_req_o  <= 1'b0;
                        mem_we_o   <= 1'b0;
                        mem_lock_o <= 1'b0;
                        pte_q      <= mem_wdata_o;
                        st_q       <= S_FILL;
                    end
                end
                S_FILL: begin
                    phys_o <= {pte_q[31:12], lin_q[11:0]};
                    done_o <= 1'b1;
                    busy_o <= 1'b0;
                    st_q   <= S_IDLE;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_base_aligned: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        dba_o[11:0] == 12'h000) else $error("base low bits not zero");

    a_flush_clears: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        dba_wr_i |=> !hit) else $error("cache hit after flush");

    a_fault_addr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        fault_o |=> fla_o == $past(lin_q)) else $error("fault addr wrong");

    a_fault_vector: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        fault_o |-> fault_vec_o == 8'h0E) else $error("bad vector");

    a_code_high_zero: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        fault_o |-> err_code_o[15:3] == 13'h0000) else $error("code high");

    a_lock_rmw: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (mem_req_o && mem_we_o) |-> mem_lock_o) else $error("unlocked rmw");

    a_acc_set: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (mem_req_o && mem_we_o) |-> mem_wdata_o[5]) else $error("no accessed");

    a_sup_pass: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (st_q == S_LOOK && hit_ok && cpl_q != 2'h3) |=> done_o)
        else $error("supervisor blocked");

    a_phys_join: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        done_o |-> phys_o[11:0] == lin_q[11:0]) else $error("offset");
endmodule
